// *** rtl/ldvc_pkg.sv ***
// package: register map, field layout, reset values and timing for lock detect and vco cal
package ldvc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_REG_ZERO   = 8'h00;
	localparam logic [7:0] OFS_IND_CFG    = 8'h04;
	localparam logic [7:0] OFS_LOCK_DELAY = 8'h08;
	localparam logic [7:0] OFS_CAL_ASSIST = 8'h0c;
	localparam logic [7:0] OFS_STATUS     = 8'h10;
	localparam logic [7:0] OFS_AMP_RESULT = 8'h14;
	// register_zero fields
	localparam int BIT_PIN_FUNC  = 2;
	localparam int BIT_CAL_START = 3;
	localparam int BIT_MUTE      = 9;
	// ind_cfg fields
	localparam int BIT_IND_TYPE  = 0;
	localparam int LSB_CAL_DIV   = 4;
	localparam int CAL_DIV_W     = 3;
	localparam logic [2:0] CAL_DIV_MAX = 3'h5;
	// lock_delay field
	localparam int LOCK_DLY_W    = 16;
	localparam int DLY_CNT_W     = LOCK_DLY_W + 2;
	// cal_assist fields
	localparam int LSB_CORE      = 0;
	localparam int CORE_W        = 3;
	localparam int BIT_CORE_F    = 4;
	localparam int BIT_BAND_F    = 5;
	localparam int BIT_AMP_F     = 6;
	localparam int LSB_BAND      = 8;
	localparam int BAND_W        = 8;
	localparam int LSB_AMP       = 16;
	localparam int AMP_W         = 9;
	// status fields
	localparam int BIT_ST_BUSY   = 0;
	localparam int BIT_ST_DLY    = 1;
	localparam int BIT_ST_CALIND = 2;
	localparam int BIT_ST_TUNIND = 3;
	localparam int BIT_ST_REFOK  = 4;
	localparam int BIT_ST_LOCK   = 5;
	localparam int LSB_ST_CORE   = 8;
	localparam int LSB_ST_BAND   = 16;
	// reset values and core codes
	localparam logic       RST_PIN_FUNC = 1'b1;
	localparam logic [2:0] CORE_MAX     = 3'h7;
	localparam logic [2:0] CORE_MIN     = 3'h1;
	localparam logic [2:0] CORE_RSVD    = 3'h0;
	// reference watchdog: no reference edge for this long means reference lost
	localparam int CLK_PERIOD_PS = 5000;
	localparam int REF_LOSS_NS   = 1000;
	localparam int REF_LOSS_CYC  = (REF_LOSS_NS * 1000) / CLK_PERIOD_PS;
	localparam int REF_CNT_W     = 10;
	// calibration sequencer states
	typedef enum logic [1:0] {
		LDVC_ST_IDLE,
		LDVC_ST_BAND,
		LDVC_ST_AMP,
		LDVC_ST_DELAY
	} ldvc_state_t;
endpackage

// *** rtl/ldvc_sm_clk_div.sv ***
// state machine clock enable: reference edges divided by two to the power of the divider field
`timescale 1ns/1ps
module ldvc_sm_clk_div (
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rstn,
	// reference edge and divider exponent
	input  wire logic       i_ref_rise,
	input  wire logic [2:0] i_div_exp,
	// one-cycle enable at state machine rate
	output logic            o_sm_en
);
	logic [4:0] cnt_ff;        // reference edges counted so far
	logic [4:0] nxt_cnt;
	logic [2:0] exp_clamped;   // values above five act as five
	logic [4:0] terminal;      // last count before the enable fires
	logic       at_end;

	assign exp_clamped = (i_div_exp > ldvc_pkg::CAL_DIV_MAX) ? ldvc_pkg::CAL_DIV_MAX : i_div_exp;
	assign terminal    = 5'((6'h01 << exp_clamped) - 6'h01);
	assign at_end      = (cnt_ff >= terminal);
	assign nxt_cnt     = at_end ? 5'h00 : 5'(cnt_ff + 5'h01);
	assign o_sm_en     = i_ref_rise & at_end; // RULE19

	// count reference edges; a divider change takes effect at once, since the terminal count is not registered
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff <= 5'h00;
		end else if (i_ref_rise) begin
			cnt_ff <= nxt_cnt; // RULE19
		end
	end
endmodule

// *** rtl/ldvc_lock_cal_ctrl.sv ***
// lock detect indicator and oscillator band and amplitude calibration control
//
// Function
// RULE1: calibration-only indicator low during cal or delay
// RULE2: delay after cal is four times count
// RULE3: calibration-only indicator holds until valid restart
// RULE4: tuning indicator high: done, delay over, locked
// RULE5: tuning indicator freezes while reference is absent
// RULE6: host supervises reference presence independently
// RULE7: mute output while tuning indicator low
// RULE8: register_zero write with start runs band cal; the code ignores the write while the reference is lost
// RULE9: host provides reference before starting cal
// RULE10: every register_zero write runs amplitude cal; the code ignores the write while the reference is lost
// RULE11: band search picks band for target frequency
// RULE12: no assist: core seven, forces cleared
// RULE13: partial assist: host loads start core
// RULE14: full assist: forced values used directly
// RULE15: host picks at least minimum core
// RULE16: any valid start core still completes
// RULE17: pin function selects lock detect or readback
// RULE18: type select picks calibration-only or tuning
// RULE19: state machine clock is reference over power two
// RULE20: lock status passes two-stage synchroniser
// RULE21: core field three bits, zero reserved
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ldvc_lock_cal_ctrl #(
	parameter int SETTLE_SM = 4   // state machine cycles per comparator step
) (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// avalon-mm slave
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// pins and analog monitors, all asynchronous
	input  wire logic        i_reference_in,
	input  wire logic        i_pd_clk,
	input  wire logic        i_vtune_locked,
	input  wire logic        i_freq_above,
	input  wire logic        i_amp_low,
	// readback serial data from the programming port, same clock
	input  wire logic        i_readback_data,
	// oscillator settings
	output logic [2:0]       o_core_select,
	output logic [7:0]       o_band_value,
	output logic [8:0]       o_amplitude_value,
	// status pin and mute
	output logic             o_status_out_pin,
	output logic             o_out_mute,
	output logic             o_cal_busy
);
	////////////////////////////////////////////////////////////////////////////////
	// elaboration check
	generate
		if (SETTLE_SM < 1 || SETTLE_SM > 255) begin : g_bad_settle
			$error("SETTLE_SM must be 1 to 255");
		end
	endgenerate

	// reserved core code falls back to the top core
	function automatic logic [2:0] core_fix(input logic [2:0] c);
		core_fix = (c == ldvc_pkg::CORE_RSVD) ? ldvc_pkg::CORE_MAX : c; // RULE21
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [2:0] ref_sync_ff;   // reference, third stage for edge detect
	logic [2:0] pd_sync_ff;    // phase detector clock
	logic [1:0] lock_sync_ff;  // tuning voltage lock monitor
	logic [1:0] fab_sync_ff;   // frequency comparator
	logic [1:0] amp_sync_ff;   // amplitude comparator
	logic       ref_rise;
	logic       pd_tick;

	// only stage one is read, by stage two; edges are taken from stages two and three
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ref_sync_ff  <= 3'h0;
			pd_sync_ff   <= 3'h0;
			lock_sync_ff <= 2'h0;
			fab_sync_ff  <= 2'h0;
			amp_sync_ff  <= 2'h0;
		end else begin
			ref_sync_ff  <= {ref_sync_ff[1:0], i_reference_in};
			pd_sync_ff   <= {pd_sync_ff[1:0], i_pd_clk};
			lock_sync_ff <= {lock_sync_ff[0], i_vtune_locked}; // RULE20
			fab_sync_ff  <= {fab_sync_ff[0], i_freq_above};
			amp_sync_ff  <= {amp_sync_ff[0], i_amp_low};
		end
	end
	assign ref_rise = ref_sync_ff[1] & ~ref_sync_ff[2];
	assign pd_tick  = pd_sync_ff[1] & ~pd_sync_ff[2];

	////////////////////////////////////////////////////////////////////////////////
	// reference watchdog
	logic [ldvc_pkg::REF_CNT_W-1:0] ref_cnt_ff;   // cycles since last reference edge
	logic                           ref_valid_ff; // reference seen recently
	logic                           ref_timeout;

	assign ref_timeout = (ref_cnt_ff == ldvc_pkg::REF_CNT_W'(ldvc_pkg::REF_LOSS_CYC));

	// a stopped reference also stops the state machine enable, so this only flags it
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ref_cnt_ff   <= '0;
			ref_valid_ff <= 1'b0;
		end else if (ref_rise) begin
			ref_cnt_ff   <= '0;
			ref_valid_ff <= 1'b1;
		end else if (ref_timeout) begin
			ref_valid_ff <= 1'b0;
		end else begin
			ref_cnt_ff   <= ref_cnt_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state machine clock enable
	logic       sm_en;
	logic [2:0] cal_div_ff;

	ldvc_sm_clk_div u_sm_div (
		.i_clk_sys  (i_clk_sys),
		.i_rstn     (i_rstn),
		.i_ref_rise (ref_rise),
		.i_div_exp  (cal_div_ff),
		.o_sm_en    (sm_en)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register bus slave: one wait cycle, then the request is taken
	logic        ack_ff;          // second cycle of a request
	logic [31:0] rdata_ff;
	logic        pin_func_ff;     // lock detect when set, readback when clear
	logic        mute_en_ff;
	logic        ind_type_ff;     // zero calibration-only, one tuning
	logic [15:0] lock_dly_ff;
	logic [2:0]  core_sel_ff;
	logic        core_f_ff;
	logic        band_f_ff;
	logic        amp_f_ff;
	logic [7:0]  band_val_ff;
	logic [8:0]  amp_val_ff;
	logic        req;
	logic        take_wr;
	logic        wr_r0;
	logic        start_band;      // band and amplitude calibration
	logic        start_amp;       // amplitude calibration only
	logic [31:0] rd_mux;
	logic [31:0] st_word;

	assign req               = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_ff;
	assign take_wr           = i_avs_write & ack_ff;
	assign wr_r0             = take_wr & (i_avs_address == ldvc_pkg::OFS_REG_ZERO);
	// a start with no reference is ignored so the held level stays honest
	assign start_band = wr_r0 & i_avs_writedata[ldvc_pkg::BIT_CAL_START] & ref_valid_ff; // RULE8
	assign start_amp  = wr_r0 & ref_valid_ff; // RULE10

	// acknowledge toggles so back-to-back requests each see one wait cycle
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff   <= req & ~ack_ff;
			rdata_ff <= rd_mux;
		end
	end
	assign o_avs_readdata = rdata_ff;

	// writable configuration
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_func_ff <= ldvc_pkg::RST_PIN_FUNC;
			mute_en_ff  <= 1'b0;
			ind_type_ff <= 1'b0;
			cal_div_ff  <= 3'h0;
			lock_dly_ff <= 16'h0000;
			core_sel_ff <= ldvc_pkg::CORE_MAX;
			core_f_ff   <= 1'b0;
			band_f_ff   <= 1'b0;
			amp_f_ff    <= 1'b0;
			band_val_ff <= 8'h00;
			amp_val_ff  <= 9'h000;
		end else if (take_wr) begin
			case (i_avs_address)
				ldvc_pkg::OFS_REG_ZERO: begin
					pin_func_ff <= i_avs_writedata[ldvc_pkg::BIT_PIN_FUNC];
					mute_en_ff  <= i_avs_writedata[ldvc_pkg::BIT_MUTE];
				end
				ldvc_pkg::OFS_IND_CFG: begin
					ind_type_ff <= i_avs_writedata[ldvc_pkg::BIT_IND_TYPE];
					cal_div_ff  <= i_avs_writedata[ldvc_pkg::LSB_CAL_DIV +: ldvc_pkg::CAL_DIV_W];
				end
				ldvc_pkg::OFS_LOCK_DELAY: begin
					lock_dly_ff <= i_avs_writedata[ldvc_pkg::LOCK_DLY_W-1:0];
				end
				ldvc_pkg::OFS_CAL_ASSIST: begin
					core_sel_ff <= i_avs_writedata[ldvc_pkg::LSB_CORE +: ldvc_pkg::CORE_W];
					core_f_ff   <= i_avs_writedata[ldvc_pkg::BIT_CORE_F];
					band_f_ff   <= i_avs_writedata[ldvc_pkg::BIT_BAND_F];
					amp_f_ff    <= i_avs_writedata[ldvc_pkg::BIT_AMP_F];
					band_val_ff <= i_avs_writedata[ldvc_pkg::LSB_BAND +: ldvc_pkg::BAND_W];
					amp_val_ff  <= i_avs_writedata[ldvc_pkg::LSB_AMP +: ldvc_pkg::AMP_W];
				end
				default: begin
					// unmapped or read-only: write ignored
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// calibration sequencer
	ldvc_pkg::ldvc_state_t         state_ff;
	logic [2:0]                    core_ff;     // core under trial or in use
	logic [7:0]                    band_ff;     // band register driven to the oscillator
	logic [8:0]                    amp_ff;      // amplitude register
	logic [3:0]                    bit_ff;      // successive approximation bit index
	logic [7:0]                    settle_ff;   // settle cycles left before judging
	logic                          band_run_ff; // this run was started with the start bit, band searched or forced
	logic [ldvc_pkg::DLY_CNT_W-1:0] dly_ff;     // phase detector cycles left
	logic                          settled;
	logic                          last_bit;
	logic                          band_stuck;  // band saturated, frequency out of core
	logic [7:0]                    band_keep;
	logic [8:0]                    amp_keep;
	logic [7:0]                    band_top;
	logic [8:0]                    amp_top;
	logic [ldvc_pkg::DLY_CNT_W-1:0] dly_load;
	logic [7:0]                    settle_load;

	assign settle_load = 8'(SETTLE_SM - 1);
	assign settled     = (settle_ff == 8'h00);
	assign last_bit    = (bit_ff == 4'h0);
	// comparator high keeps the trial bit: oscillator above target needs more capacitance
	assign band_keep   = fab_sync_ff[1] ? band_ff
	                   : (band_ff & ~(8'h01 << bit_ff[2:0])); // RULE11
	assign band_stuck  = (band_keep == 8'hff);
	assign band_top    = 8'h80;
	assign amp_keep    = amp_sync_ff[1] ? amp_ff : (amp_ff & ~(9'h001 << bit_ff));
	assign amp_top     = 9'h100;
	assign dly_load    = {lock_dly_ff, 2'b00}; // RULE2

	// a new start always wins over a run in progress
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff    <= ldvc_pkg::LDVC_ST_IDLE;
			core_ff     <= ldvc_pkg::CORE_MAX;
			band_ff     <= 8'h00;
			amp_ff      <= 9'h000;
			bit_ff      <= 4'h0;
			settle_ff   <= 8'h00;
			band_run_ff <= 1'b0;
			dly_ff      <= '0;
		end else if (start_amp) begin
			band_run_ff <= start_band;
			settle_ff   <= settle_load;
			if (start_band) begin
				core_ff <= core_fix(core_sel_ff); // RULE13
			end
			if (start_band && band_f_ff) begin
				band_ff <= band_val_ff; // RULE14
			end else if (start_band) begin
				band_ff <= band_top;
			end
			if (start_band && !band_f_ff) begin
				state_ff <= ldvc_pkg::LDVC_ST_BAND;
				bit_ff   <= 4'(ldvc_pkg::BAND_W - 1);
			end else if (amp_f_ff) begin
				// forced amplitude: nothing to search, go straight on
				amp_ff   <= amp_val_ff; // RULE14
				state_ff <= start_band ? ldvc_pkg::LDVC_ST_DELAY : ldvc_pkg::LDVC_ST_IDLE;
				dly_ff   <= dly_load;
			end else begin
				state_ff <= ldvc_pkg::LDVC_ST_AMP;
				amp_ff   <= amp_top;
				bit_ff   <= 4'(ldvc_pkg::AMP_W - 1);
			end
		end else begin
			case (state_ff)
				ldvc_pkg::LDVC_ST_IDLE: begin
					// hold settings
				end
				ldvc_pkg::LDVC_ST_BAND: begin
					if (sm_en && !settled) begin
						settle_ff <= settle_ff - 8'h01;
					end else if (sm_en && !last_bit) begin
						band_ff   <= band_keep | (8'h01 << (bit_ff[2:0] - 3'h1));
						bit_ff    <= bit_ff - 4'h1;
						settle_ff <= settle_load;
					end else if (sm_en && band_stuck && !core_f_ff
					             && core_ff > ldvc_pkg::CORE_MIN) begin
						// step down a core and search again; costs time, not correctness
						core_ff   <= core_ff - 3'h1; // RULE16
						band_ff   <= band_top;
						bit_ff    <= 4'(ldvc_pkg::BAND_W - 1);
						settle_ff <= settle_load;
					end else if (sm_en) begin
						band_ff   <= band_keep; // RULE11
						settle_ff <= settle_load;
						if (amp_f_ff) begin
							amp_ff   <= amp_val_ff;
							state_ff <= ldvc_pkg::LDVC_ST_DELAY;
							dly_ff   <= dly_load;
						end else begin
							amp_ff   <= amp_top;
							bit_ff   <= 4'(ldvc_pkg::AMP_W - 1);
							state_ff <= ldvc_pkg::LDVC_ST_AMP;
						end
					end
				end
				ldvc_pkg::LDVC_ST_AMP: begin
					if (sm_en && !settled) begin
						settle_ff <= settle_ff - 8'h01;
					end else if (sm_en && !last_bit) begin
						amp_ff    <= amp_keep | (9'h001 << (bit_ff - 4'h1));
						bit_ff    <= bit_ff - 4'h1;
						settle_ff <= settle_load;
					end else if (sm_en) begin
						amp_ff   <= amp_keep; // RULE10
						dly_ff   <= dly_load;
						state_ff <= band_run_ff ? ldvc_pkg::LDVC_ST_DELAY
						                        : ldvc_pkg::LDVC_ST_IDLE;
					end
				end
				ldvc_pkg::LDVC_ST_DELAY: begin
					if (dly_ff == '0) begin
						state_ff <= ldvc_pkg::LDVC_ST_IDLE;
					end else if (pd_tick) begin
						dly_ff <= dly_ff - 1'b1; // RULE2
					end
				end
				default: begin
					state_ff <= ldvc_pkg::LDVC_ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// indicators, status pin and mute
	logic busy;            // any search running
	logic dly_run;         // lock delay timer running
	logic cal_done_ff;     // band calibration and delay finished
	logic cal_ind_ff;      // calibration-only indicator
	logic tune_ind_ff;     // tuning-and-calibration indicator
	logic lock_sm_ff;      // lock status sampled at state machine rate
	logic pin_ff;
	logic mute_ff;
	logic ind_sel;

	assign busy    = (state_ff == ldvc_pkg::LDVC_ST_BAND) | (state_ff == ldvc_pkg::LDVC_ST_AMP);
	assign dly_run = (state_ff == ldvc_pkg::LDVC_ST_DELAY);
	assign ind_sel = ind_type_ff ? tune_ind_ff : cal_ind_ff; // RULE18

	// calibration-only level moves only on a valid start or at the end of the delay
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cal_done_ff <= 1'b0;
			cal_ind_ff  <= 1'b0;
		end else if (start_band) begin
			cal_done_ff <= 1'b0;
			cal_ind_ff  <= 1'b0; // RULE1
		end else if (band_run_ff && dly_run && dly_ff == '0) begin
			cal_done_ff <= 1'b1;
			cal_ind_ff  <= 1'b1; // RULE3
		end
	end

	// tuning indicator clears on a band start, otherwise updates only on state machine edges while the reference is good
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			lock_sm_ff  <= 1'b0;
			tune_ind_ff <= 1'b0;
		end else if (start_band) begin
			tune_ind_ff <= 1'b0;
		end else if (sm_en && ref_valid_ff) begin
			lock_sm_ff  <= lock_sync_ff[1]; // RULE20
			tune_ind_ff <= cal_done_ff & ~busy & ~dly_run & lock_sm_ff; // RULE4 RULE5
		end
	end

	// pin and mute registered so they never glitch
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_ff  <= 1'b0;
			mute_ff <= 1'b0;
		end else begin
			pin_ff  <= pin_func_ff ? ind_sel : i_readback_data; // RULE17
			mute_ff <= mute_en_ff & ~tune_ind_ff; // RULE7
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux and outputs
	assign st_word = (32'(busy) << ldvc_pkg::BIT_ST_BUSY)
	               | (32'(dly_run) << ldvc_pkg::BIT_ST_DLY)
	               | (32'(cal_ind_ff) << ldvc_pkg::BIT_ST_CALIND)
	               | (32'(tune_ind_ff) << ldvc_pkg::BIT_ST_TUNIND)
	               | (32'(ref_valid_ff) << ldvc_pkg::BIT_ST_REFOK)
	               | (32'(lock_sm_ff) << ldvc_pkg::BIT_ST_LOCK)
	               | (32'(core_ff) << ldvc_pkg::LSB_ST_CORE)
	               | (32'(band_ff) << ldvc_pkg::LSB_ST_BAND);

	always_comb begin
		case (i_avs_address)
			ldvc_pkg::OFS_REG_ZERO:   rd_mux = (32'(pin_func_ff) << ldvc_pkg::BIT_PIN_FUNC)
			                                 | (32'(mute_en_ff) << ldvc_pkg::BIT_MUTE);
			ldvc_pkg::OFS_IND_CFG:    rd_mux = 32'(ind_type_ff)
			                                 | (32'(cal_div_ff) << ldvc_pkg::LSB_CAL_DIV);
			ldvc_pkg::OFS_LOCK_DELAY: rd_mux = 32'(lock_dly_ff);
			ldvc_pkg::OFS_CAL_ASSIST: rd_mux = 32'(core_sel_ff)
			                                 | (32'(core_f_ff) << ldvc_pkg::BIT_CORE_F)
			                                 | (32'(band_f_ff) << ldvc_pkg::BIT_BAND_F)
			                                 | (32'(amp_f_ff) << ldvc_pkg::BIT_AMP_F)
			                                 | (32'(band_val_ff) << ldvc_pkg::LSB_BAND)
			                                 | (32'(amp_val_ff) << ldvc_pkg::LSB_AMP);
			ldvc_pkg::OFS_STATUS:     rd_mux = st_word;
			ldvc_pkg::OFS_AMP_RESULT: rd_mux = 32'(amp_ff);
			default:                  rd_mux = 32'h0000_0000;
		endcase
	end

	assign o_core_select     = core_ff;
	assign o_band_value      = band_ff;
	assign o_amplitude_value = amp_ff;
	assign o_status_out_pin  = pin_ff;
	assign o_out_mute        = mute_ff;
	assign o_cal_busy        = busy | dly_run;
endmodule

// *** bench/ldvc_checker.sv ***
// checker: bus, calibration and status pin properties of the lock detect controller
`timescale 1ns/1ps
module ldvc_checker (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// observed ports
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic        o_avs_waitrequest,
	input  wire logic        i_readback_data,
	input  wire logic [2:0]  o_core_select,
	input  wire logic        o_status_out_pin,
	input  wire logic        o_out_mute,
	input  wire logic        o_cal_busy
);
	logic pin_sel_ff; // shadow of pin function
	logic type_ff;    // shadow of indicator type
	logic mute_ff;    // shadow of mute on unlock
	wire  take = i_avs_write & ~o_avs_waitrequest; // write accepted at this edge
	// shadow follows accepted writes only, so it matches the design registers
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_sel_ff <= 1'b1;
			type_ff    <= 1'b0;
			mute_ff    <= 1'b0;
		end else if (take && i_avs_address == 8'h00) begin
			pin_sel_ff <= i_avs_writedata[2];
			mute_ff    <= i_avs_writedata[9];
		end else if (take && i_avs_address == 8'h04) begin
			type_ff <= i_avs_writedata[0];
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// an amplitude-only run also raises busy, so only start writes count
	sequence s_go;
		$rose(o_cal_busy) && $past(i_avs_writedata[3]);
	endsequence
	chk_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("waitrequest not one cycle");
	chk_busy_cause: assert property ($rose(o_cal_busy) |-> $past(take && i_avs_address == 8'h00))
		else $error("busy without register_zero write");
	chk_cal_pin_low: assert property (s_go ##0 (pin_sel_ff && !type_ff) |=> !o_status_out_pin [*4])
		else $error("cal-only pin high during cal");
	chk_tune_pin_low: assert property (s_go ##0 (pin_sel_ff && type_ff) |=> !o_status_out_pin [*4])
		else $error("tuning pin high during cal");
	chk_pin_hold: assert property (pin_sel_ff && !type_ff && o_status_out_pin && !i_avs_write
		&& !$past(i_avs_write) |=> o_status_out_pin)
		else $error("cal-only pin dropped");
	chk_mute_on_cal: assert property (s_go ##0 mute_ff |=> o_out_mute)
		else $error("no mute at cal start");
	chk_mute_off: assert property (!mute_ff |=> !o_out_mute)
		else $error("mute while disabled");
	chk_readback_route: assert property (!pin_sel_ff |=> o_status_out_pin == $past(i_readback_data))
		else $error("readback not routed");
	chk_core_valid: assert property (o_core_select != 3'h0)
		else $error("reserved core");
	cover property (s_go);
	cover property ($rose(o_status_out_pin));
	cover property ($rose(o_out_mute));
endmodule
bind ldvc_lock_cal_ctrl ldvc_checker i_ldvc_checker (.i_clk_sys, .i_rstn, .i_avs_address,
	.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_waitrequest, .i_readback_data,
	.o_core_select, .o_status_out_pin, .o_out_mute, .o_cal_busy);

// *** bench/tb_top.sv ***
// testbench: register bus tasks and calibration scenarios
`timescale 1ns/1ps
module tb_top;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdq;
	logic [31:0] rdata;
	logic wrq, pin, mute, busy;
	logic refin = 1'b0;
	logic pd = 1'b0;
	logic ref_on = 1'b1; // reference gate, low stops the reference
	logic lck = 1'b1;
	logic fab = 1'b0;
	logic alow = 1'b0;
	logic rbd = 1'b0;
	logic [2:0] core;
	logic [7:0] band;
	logic [8:0] amp;
	int errors = 0, checked = 0, cyc = 0, d0, n;
	logic pmid; // pin level seen mid-calibration, kept four-state so an unknown fails
	ldvc_lock_cal_ctrl #(.SETTLE_SM(1)) i_ldvc_lock_cal_ctrl (.i_clk_sys, .i_rstn,
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.o_avs_readdata(rdq), .o_avs_waitrequest(wrq), .i_reference_in(refin),
		.i_pd_clk(pd), .i_vtune_locked(lck), .i_freq_above(fab), .i_amp_low(alow),
		.i_readback_data(rbd), .o_core_select(core), .o_band_value(band),
		.o_amplitude_value(amp), .o_status_out_pin(pin), .o_out_mute(mute), .o_cal_busy(busy));
	initial forever #2.5 i_clk_sys = ~i_clk_sys;
	// reference at 25 MHz and phase detector at 50 MHz, off the sampling edge
	initial forever #20 refin = ref_on ? ~refin : 1'b0;
	initial forever #10 pd = ~pd;
	task automatic print_verdict();
		if (errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus transfer: request held until waitrequest is sampled low at a rising edge,
	// read data taken at that same edge, then one idle edge so the next request rises cleanly
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge i_clk_sys); while (wrq !== 1'b0 && ++k < 50);
		rdata = rdq;
		if (wrq !== 1'b0) begin
			errors++;
			$display("CHECK FAILED at %0t: no bus answer", $time);
		end
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_clk_sys);
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge i_clk_sys);
	endtask
	// start a calibration with config d and time the busy window
	task automatic cal(input logic [31:0] d, output int len);
		int t0;
		bus(1'b1, 8'h00, d);
		idle(2);
		pmid = pin;
		t0 = cyc;
		while (busy !== 1'b0 && cyc - t0 < 8000) idle(1);
		len = cyc - t0;
		chk(32'(busy), 32'h0);
		idle(3);
	endtask
	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		@(posedge i_clk_sys);
		bus(1'b0, 8'h00, 0); chk(rdata, 32'h4);
		bus(1'b0, 8'h0c, 0); chk(rdata, 32'h7);
		bus(1'b1, 8'h10, 32'hffffffff);
		bus(1'b0, 8'h20, 0); chk(rdata, 32'h0);
		bus(1'b1, 8'h04, 32'h50);
		bus(1'b0, 8'h04, 0); chk(rdata, 32'h50);
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h08, 0);
		cal(32'h0c, d0);
		bus(1'b1, 8'h08, 8);
		cal(32'h0c, n); chk(pmid, 0);
		// 4 x 8 pd cycles of 4 clocks each, give or take the reference phase at start
		chk(32'((n - d0 > 112) && (n - d0 < 144)), 1);
		chk(pin, 1);
		lck <= 1'b0;
		ref_on <= 1'b0;
		idle(300);
		bus(1'b1, 8'h00, 32'h0c);
		idle(20); chk({busy, pin}, 2'b01);
		ref_on <= 1'b1;
		lck <= 1'b1;
		idle(20);
		bus(1'b1, 8'h0c, 32'h01a55a73);
		cal(32'h0c, n); chk({core, band, amp}, {3'h3, 8'h5a, 9'h1a5});
		fab <= 1'b1;
		alow <= 1'b1;
		bus(1'b1, 8'h0c, 32'h2);
		cal(32'h0c, n); chk({core, band, amp}, {3'h1, 8'hff, 9'h1ff});
		fab <= 1'b0;
		alow <= 1'b0;
		bus(1'b1, 8'h04, 32'h1);
		cal(32'h20c, n);
		idle(60); chk({pin, mute}, 2'b10);
		lck <= 1'b0;
		idle(80); chk({pin, mute}, 2'b01);
		lck <= 1'b1;
		ref_on <= 1'b0;
		idle(300); chk(pin, 0);
		bus(1'b0, 8'h10, 0); chk(32'(rdata[4]), 32'h0);
		ref_on <= 1'b1;
		idle(120); chk(pin, 1);
		bus(1'b1, 8'h00, 32'h0);
		rbd <= 1'b1;
		idle(3); chk({pin, mute}, 2'b10);
		rbd <= 1'b0;
		idle(3); chk(pin, 0);
		print_verdict();
	end
endmodule
